// ---- common/uvfr_pkg.sv ----
// Package with register map, field layout and timing constants for the under-voltage fault response
package uvfr_pkg;
    localparam logic [7:0] UVFR_ACTION_ADDR   = 8'h45;
    localparam logic [7:0] UVFR_ACTION_RESET  = 8'h80;
    localparam int         UVFR_RESP_HI       = 7;
    localparam int         UVFR_RESP_LO       = 6;
    localparam int         UVFR_RETRY_HI      = 5;
    localparam int         UVFR_RETRY_LO      = 3;
    localparam int         UVFR_DELAY_HI      = 2;
    localparam int         UVFR_DELAY_LO      = 0;
    localparam logic [1:0] UVFR_RESP_IGNORE   = 2'h0;
    localparam logic [1:0] UVFR_RESP_DELAYED  = 2'h1;
    localparam logic [1:0] UVFR_RESP_SHUTDOWN = 2'h2;
    localparam logic [1:0] UVFR_RESP_FOLLOW   = 2'h3;
    localparam logic [2:0] UVFR_RETRY_NONE    = 3'h0;
    localparam logic [2:0] UVFR_RETRY_ALWAYS  = 3'h7;
    localparam int         UVFR_UNIT_W        = 16;
    localparam logic [15:0] UVFR_UNIT_RESET   = 16'h0028;
    localparam int         UVFR_CNT_W         = 24;
    typedef enum logic [4:0] {
        UVFR_RUN     = 5'h01,
        UVFR_GRACE   = 5'h02,
        UVFR_WAIT    = 5'h04,
        UVFR_LOCKED  = 5'h08,
        UVFR_HOLDOFF = 5'h10
    } uvfr_state_t;
endpackage : uvfr_pkg

// ---- design/uvfr_ctrl.sv ----
// Under-voltage fault response controller with its byte-wide setting register
//
// Summary of operation
// - Action 00 keeps output on despite fault.
// - Action 01 runs delay, then applies retries.
// - Action 10 disables immediately, then applies retries.
// - Action 11 disables only while fault persists.
// - Retry 000 means no restart, stay off.
// - Retry 1..6 gives that many restarts.
// - Retry 111 restarts until commanded off.
// - Restart spacing is delay count times unit.
// - Status, clear-all, reset or off-on clear fault.
// - Delay code n means 2**n time units.
`timescale 1ns/1ps
module uvfr_ctrl import uvfr_pkg::*; #(
    parameter int UNIT_W = UVFR_UNIT_W
) (
    input  wire logic              clock_in,
    input  wire logic              sys_rst_in,
    input  wire logic              clk_en_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    input  wire logic [7:0]        reg_addr_in,
    input  wire logic [7:0]        reg_wdata_in,
    output logic      [7:0]        reg_rdata_out,
    output logic                   reg_ack_out,
    input  wire logic [UNIT_W-1:0] unit_cycles_in,
    input  wire logic              uv_fault_in,
    input  wire logic              run_cmd_in,
    input  wire logic              clear_all_in,
    input  wire logic              clear_bit_in,
    input  wire logic              other_fault_in,
    output logic                   output_en_out,
    output logic                   fault_latched_out,
    output logic [2:0]             attempts_out,
    output logic [4:0]             state_out
);
    uvfr_state_t state_r;
    uvfr_state_t state_nxt;
    logic [7:0]  setting_r;
    logic [7:0]  setting_nxt;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic        latch_r;
    logic        latch_nxt;
    logic [2:0]  tries_r;
    logic [2:0]  tries_nxt;
    logic        en_r;
    logic        en_nxt;
    logic        run_d_r;
    logic        timer_start;
    logic        timer_done;
    logic        clear_evt;
    logic [1:0]  resp;
    logic [2:0]  retries;

    assign resp    = setting_r[UVFR_RESP_HI:UVFR_RESP_LO];
    assign retries = setting_r[UVFR_RETRY_HI:UVFR_RETRY_LO];
    // Off-then-on is seen as the rising edge of the run command
    assign clear_evt = clear_bit_in | clear_all_in | (run_cmd_in & ~run_d_r);

    uvfr_timer #(
        .UNIT_W (UNIT_W),
        .CNT_W  (UVFR_CNT_W)
    ) u_timer (
        .clock_in       (clock_in),
        .sys_rst_in     (sys_rst_in),
        .clk_en_in      (clk_en_in),
        .start_in       (timer_start),
        .code_in        (setting_r[UVFR_DELAY_HI:UVFR_DELAY_LO]),
        .unit_cycles_in (unit_cycles_in),
        .done_out       (timer_done)
    );

    // Register port: one byte, read data registered with a one-cycle ack
    always_comb begin
        setting_nxt = setting_r;
        rdata_nxt   = rdata_r;
        ack_nxt     = reg_wr_in | reg_rd_in;
        if (reg_wr_in && reg_addr_in == UVFR_ACTION_ADDR) begin
            setting_nxt = reg_wdata_in;
        end
        if (reg_rd_in) begin
            rdata_nxt = (reg_addr_in == UVFR_ACTION_ADDR) ? setting_r : 8'h00;
        end
    end

    always_comb begin
        state_nxt   = state_r;
        latch_nxt   = latch_r;
        tries_nxt   = tries_r;
        en_nxt      = en_r;
        timer_start = 1'b0;
        case (state_r)
            UVFR_RUN: begin
                en_nxt = run_cmd_in;
                if (run_cmd_in && uv_fault_in) begin
                    latch_nxt = 1'b1;
                    case (resp)
                        UVFR_RESP_IGNORE: state_nxt = UVFR_RUN;
                        UVFR_RESP_DELAYED: begin
                            timer_start = 1'b1;
                            state_nxt   = UVFR_GRACE;
                        end
                        UVFR_RESP_SHUTDOWN: begin
                            en_nxt    = 1'b0;
                            state_nxt = UVFR_HOLDOFF;
                        end
                        default: begin
                            en_nxt    = 1'b0;
                            state_nxt = UVFR_HOLDOFF;
                        end
                    endcase
                    if (resp == UVFR_RESP_SHUTDOWN) begin
                        if (retries == UVFR_RETRY_NONE) begin
                            state_nxt = UVFR_LOCKED;
                        end else begin
                            timer_start = 1'b1;
                            state_nxt   = UVFR_WAIT;
                        end
                    end
                end
            end
            UVFR_GRACE: begin
                if (timer_done) begin
                    if (!uv_fault_in) begin
                        state_nxt = UVFR_RUN;
                    end else begin
                        en_nxt = 1'b0;
                        if (retries == UVFR_RETRY_NONE) begin
                            state_nxt = UVFR_LOCKED;
                        end else begin
                            timer_start = 1'b1;
                            state_nxt   = UVFR_WAIT;
                        end
                    end
                end
            end
            UVFR_WAIT: begin
                // Restart spacing measured from the previous attempt
                if (timer_done) begin
                    if (retries != UVFR_RETRY_ALWAYS && tries_r >= retries) begin
                        en_nxt    = 1'b0;
                        state_nxt = UVFR_LOCKED;
                    end else begin
                        if (retries != UVFR_RETRY_ALWAYS) begin
                            tries_nxt = tries_r + 3'h1;
                        end
                        // Each attempt really switches the output back on
                        en_nxt = 1'b1;
                        timer_start = 1'b1;
                        if (!uv_fault_in) begin
                            state_nxt = UVFR_RUN;
                        end
                    end
                end else if (en_r && uv_fault_in) begin
                    // Fault still present during the attempt, so that attempt failed
                    en_nxt = 1'b0;
                end
            end
            UVFR_HOLDOFF: begin
                en_nxt = 1'b0;
                if (resp == UVFR_RESP_FOLLOW && !uv_fault_in) begin
                    en_nxt    = run_cmd_in;
                    state_nxt = UVFR_RUN;
                end
            end
            UVFR_LOCKED: en_nxt = 1'b0;
            default: begin
                state_nxt = UVFR_RUN;
                en_nxt    = 1'b0;
            end
        endcase
        if (!run_cmd_in || other_fault_in) begin
            // Commanded off or another shutdown ends any retry sequence
            en_nxt    = 1'b0;
            state_nxt = UVFR_RUN;
            tries_nxt = 3'h0;
        end
        if (clear_evt) begin
            tries_nxt = 3'h0;
            if (!(run_cmd_in && uv_fault_in)) begin
                latch_nxt = 1'b0;
            end
            if (state_r == UVFR_LOCKED) begin
                state_nxt = UVFR_RUN;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state_r   <= UVFR_RUN;
            setting_r <= UVFR_ACTION_RESET;
            rdata_r   <= 8'h00;
            ack_r     <= 1'b0;
            latch_r   <= 1'b0;
            tries_r   <= 3'h0;
            en_r      <= 1'b0;
            run_d_r   <= 1'b0;
        end else if (clk_en_in) begin
            state_r   <= state_nxt;
            setting_r <= setting_nxt;
            rdata_r   <= rdata_nxt;
            ack_r     <= ack_nxt;
            latch_r   <= latch_nxt;
            tries_r   <= tries_nxt;
            en_r      <= en_nxt;
            run_d_r   <= run_cmd_in;
        end
    end

    assign reg_rdata_out     = rdata_r;
    assign reg_ack_out       = ack_r;
    assign output_en_out     = en_r;
    assign fault_latched_out = latch_r;
    assign attempts_out      = tries_r;
    assign state_out         = state_r;
endmodule : uvfr_ctrl

// ---- design/uvfr_timer.sv ----
// Delay timer counting 2**code time units of a programmable cycle length
`timescale 1ns/1ps
module uvfr_timer import uvfr_pkg::*; #(
    parameter int UNIT_W = UVFR_UNIT_W,
    parameter int CNT_W  = UVFR_CNT_W
) (
    input  wire logic              clock_in,
    input  wire logic              sys_rst_in,
    input  wire logic              clk_en_in,
    input  wire logic              start_in,
    input  wire logic [2:0]        code_in,
    input  wire logic [UNIT_W-1:0] unit_cycles_in,
    output logic                   done_out
);
    logic [UNIT_W-1:0] unit_r;
    logic [UNIT_W-1:0] unit_nxt;
    logic [CNT_W-1:0]  left_r;
    logic [CNT_W-1:0]  left_nxt;
    logic              run_r;
    logic              run_nxt;
    logic              done_r;
    logic              done_nxt;

    always_comb begin
        unit_nxt = unit_r;
        left_nxt = left_r;
        run_nxt  = run_r;
        done_nxt = 1'b0;
        if (start_in) begin
            // Units as a power of two; a zero unit length still counts one cycle
            left_nxt = CNT_W'(1) << code_in;
            unit_nxt = (unit_cycles_in == '0) ? UNIT_W'(1) : unit_cycles_in;
            run_nxt  = 1'b1;
        end else if (run_r) begin
            if (unit_r > UNIT_W'(1)) begin
                unit_nxt = unit_r - UNIT_W'(1);
            end else if (left_r > CNT_W'(1)) begin
                left_nxt = left_r - CNT_W'(1);
                unit_nxt = (unit_cycles_in == '0) ? UNIT_W'(1) : unit_cycles_in;
            end else begin
                run_nxt  = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            unit_r <= '0;
            left_r <= '0;
            run_r  <= 1'b0;
            done_r <= 1'b0;
        end else if (clk_en_in) begin
            unit_r <= unit_nxt;
            left_r <= left_nxt;
            run_r  <= run_nxt;
            done_r <= done_nxt;
        end
    end

    assign done_out = done_r;
endmodule : uvfr_timer

// ---- testbench/uvfr_ctrl_properties.sv ----
// Port-level assertions for the under-voltage fault response controller
`timescale 1ns/1ps
module uvfr_ctrl_properties import uvfr_pkg::*; (
    input wire logic       clock_in,
    input wire logic       sys_rst_in,
    input wire logic       clk_en_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       reg_ack_out,
    input wire logic       uv_fault_in,
    input wire logic       run_cmd_in,
    input wire logic       clear_all_in,
    input wire logic       clear_bit_in,
    input wire logic       other_fault_in,
    input wire logic       output_en_out,
    input wire logic       fault_latched_out,
    input wire logic [2:0] attempts_out,
    input wire logic [4:0] state_out
);
    logic [7:0] set_r;
    logic [7:0] set_nxt;
    // Shadow of the setting, rebuilt from the write strobes alone
    always_comb begin
        set_nxt = set_r;
        if (clk_en_in && reg_wr_in && reg_addr_in == UVFR_ACTION_ADDR) begin
            set_nxt = reg_wdata_in;
        end
    end
    always_ff @(posedge clock_in) begin
        set_r <= sys_rst_in ? UVFR_ACTION_RESET : set_nxt;
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_hit(logic [1:0] r);
        clk_en_in && state_out == UVFR_RUN && run_cmd_in && uv_fault_in && !other_fault_in
            && set_r[7:6] == r;
    endsequence
    property p_ack; clk_en_in && (reg_rd_in || reg_wr_in) |=> reg_ack_out; endproperty
    property p_read;
        clk_en_in && reg_rd_in && !reg_wr_in |=> reg_rdata_out ==
            ($past(reg_addr_in) == UVFR_ACTION_ADDR ? $past(set_r) : 8'h00);
    endproperty
    property p_ignore; s_hit(2'h0) ##0 output_en_out |=> output_en_out; endproperty
    property p_grace; s_hit(2'h1) ##0 output_en_out |=> output_en_out; endproperty
    property p_shutdown; s_hit(2'h2) |=> !output_en_out && fault_latched_out; endproperty
    property p_follow; s_hit(2'h3) |=> !output_en_out; endproperty
    property p_locked;
        state_out == UVFR_LOCKED && clk_en_in && run_cmd_in && !clear_all_in && !clear_bit_in
            |=> !output_en_out;
    endproperty
    property p_clear;
        clk_en_in && (clear_all_in || clear_bit_in) && !uv_fault_in |=> !fault_latched_out;
    endproperty
    property p_off; clk_en_in && !run_cmd_in |=> attempts_out == 3'h0 && !output_en_out; endproperty
    a_ack: assert property (p_ack) else $error("no ack after access");
    a_read: assert property (p_read) else $error("read data wrong");
    a_ignore: assert property (p_ignore) else $error("ignore dropped output");
    a_grace: assert property (p_grace) else $error("delayed response cut early");
    a_shutdown: assert property (p_shutdown) else $error("shutdown missed");
    a_follow: assert property (p_follow) else $error("follow mode stayed on");
    a_locked: assert property (p_locked) else $error("locked output enabled");
    a_clear: assert property (p_clear) else $error("latch not cleared");
    a_off: assert property (p_off) else $error("off did not reset attempts");
endmodule : uvfr_ctrl_properties
bind uvfr_ctrl uvfr_ctrl_properties u_props (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_ack_out(reg_ack_out), .uv_fault_in(uv_fault_in), .run_cmd_in(run_cmd_in),
    .clear_all_in(clear_all_in), .clear_bit_in(clear_bit_in), .other_fault_in(other_fault_in),
    .output_en_out(output_en_out), .fault_latched_out(fault_latched_out),
    .attempts_out(attempts_out), .state_out(state_out));

// ---- testbench/uvfr_ctrl_tb.sv ----
// Self-checking bench for the under-voltage fault response controller
`timescale 1ns/1ps
module uvfr_ctrl_tb import uvfr_pkg::*; ;
    localparam int UNIT = 4;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, uv = 1'b0, run = 1'b0;
    logic clr_all = 1'b0, clr_bit = 1'b0, oth = 1'b0, wr, rd, ack, en, lat, en_q = 1'b0;
    logic [7:0] addr, wdat, rdat, rq;
    logic [2:0] att;
    logic [4:0] st;
    int miscompares = 0, n_checks = 0, rises = 0, cyc_n = 0, last_rise = 0, gap = 0, r0;
    logic [7:0] ra [4] = '{8'h45, 8'h45, 8'h10, 8'h45};
    logic [7:0] rv [4] = '{8'hc5, 8'h3f, 8'haa, 8'h00};
    logic [7:0] re [4] = '{8'hc5, 8'h3f, 8'h00, 8'h00};
    always #12.5 clk = ~clk;
    uvfr_host host (.clock_in(clk), .ack_in(ack), .rdata_in(rdat), .wr_out(wr), .rd_out(rd),
                    .addr_out(addr), .wdata_out(wdat));
    uvfr_ctrl #(.UNIT_W(16)) dut (.clock_in(clk), .sys_rst_in(rst), .clk_en_in(ce),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdat),
        .reg_rdata_out(rdat), .reg_ack_out(ack), .unit_cycles_in(16'(UNIT)),
        .uv_fault_in(uv), .run_cmd_in(run), .clear_all_in(clr_all), .clear_bit_in(clr_bit),
        .other_fault_in(oth), .output_en_out(en), .fault_latched_out(lat),
        .attempts_out(att), .state_out(st));
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        en_q <= en;
        if (en === 1'b1 && en_q === 1'b0) begin
            rises <= rises + 1;
            gap <= cyc_n - last_rise;
            last_rise <= cyc_n;
        end
    end
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task set(input logic [7:0] v);
        host.acc(1'b1, UVFR_ACTION_ADDR, v, rq);
    endtask : set
    task summarize;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    // Whole run is a few hundred cycles; ten times that means a hang
    initial begin
        #(25 * 4000);
        miscompares++;
        summarize();
    end
    initial begin
        cyc(8);
        rst <= 1'b0;
        host.acc(1'b0, UVFR_ACTION_ADDR, 8'h00, rq);
        chk("reset setting", UVFR_ACTION_RESET, rq);
        for (int i = 0; i < 4; i++) begin
            host.acc(1'b1, ra[i], rv[i], rq);
            host.acc(1'b0, ra[i], 8'h00, rq);
            chk("readback", re[i], rq);
        end
        @(posedge clk) run <= 1'b1;
        cyc(3);
        @(posedge clk) uv <= 1'b1;
        cyc(6);
        chk("ignore en", 8'h01, en);
        chk("ignore latch", 8'h01, lat);
        @(posedge clk) uv <= 1'b0;
        clr_all <= 1'b1;
        @(posedge clk) clr_all <= 1'b0;
        cyc(2);
        chk("clear all", 8'h00, lat);
        set(8'h80);
        @(posedge clk) uv <= 1'b1;
        cyc(2);
        chk("shutdown en", 8'h00, en);
        cyc(30);
        @(posedge clk) uv <= 1'b0;
        cyc(4);
        chk("no retry en", 8'h00, en);
        chk("locked state", 8'h08, st);
        @(posedge clk) clr_bit <= 1'b1;
        @(posedge clk) clr_bit <= 1'b0;
        cyc(3);
        chk("bit clear", 8'h00, lat);
        chk("resume en", 8'h01, en);
        set(8'hc0);
        @(posedge clk) uv <= 1'b1;
        cyc(2);
        chk("follow off", 8'h00, en);
        @(posedge clk) uv <= 1'b0;
        cyc(3);
        chk("follow on", 8'h01, en);
        @(posedge clk) ce <= 1'b0;
        uv <= 1'b1;
        cyc(4);
        chk("freeze en", 8'h01, en);
        chk("freeze state", 8'h01, st);
        @(posedge clk) ce <= 1'b1;
        uv <= 1'b0;
        cyc(2);
        set(8'h51);
        r0 = rises;
        @(posedge clk) uv <= 1'b1;
        cyc(3);
        chk("grace en", 8'h01, en);
        cyc(100);
        chk("two retries", 8'h02, 8'(rises - r0));
        chk("attempts", 8'h02, att);
        chk("locked en", 8'h00, en);
        chk("retry locked state", 8'h08, st);
        chk("spacing", 8'h01, 8'(gap >= 2 * UNIT && gap <= 2 * UNIT + 4));
        @(posedge clk) run <= 1'b0;
        uv <= 1'b0;
        cyc(2);
        chk("off attempts", 8'h00, att);
        @(posedge clk) run <= 1'b1;
        cyc(3);
        chk("off-on clear", 8'h00, lat);
        set(8'hb8);
        r0 = rises;
        @(posedge clk) uv <= 1'b1;
        cyc(100);
        chk("endless", 8'h01, 8'(rises - r0 > 6));
        @(posedge clk) oth <= 1'b1;
        cyc(3);
        r0 = rises;
        cyc(20);
        chk("other stop", 8'h00, 8'(rises - r0));
        chk("other en", 8'h00, en);
        @(posedge clk) rst <= 1'b1;
        cyc(2);
        chk("reset latch", 8'h00, lat);
        @(posedge clk) rst <= 1'b0;
        uv <= 1'b0;
        oth <= 1'b0;
        host.acc(1'b0, UVFR_ACTION_ADDR, 8'h00, rq);
        chk("reset setting again", UVFR_ACTION_RESET, rq);
        chk("reset en", 8'h01, en);
        summarize();
    end
endmodule : uvfr_ctrl_tb

// ---- testbench/uvfr_host.sv ----
// Host model issuing single-byte setting accesses
`timescale 1ns/1ps
module uvfr_host (
    input  wire logic       clock_in,
    input  wire logic       ack_in,
    input  wire logic [7:0] rdata_in,
    output logic            wr_out,
    output logic            rd_out,
    output logic [7:0]      addr_out,
    output logic [7:0]      wdata_out
);
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end
    // Idle bus shows inverted values so stale data is never mistaken for fresh
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clock_in);
        wr_out <= w;
        rd_out <= !w;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clock_in);
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
        @(posedge clock_in);
        q = (ack_in === 1'b1) ? rdata_in : 8'hxx;
    endtask : acc
endmodule : uvfr_host
